// ---- verilog/tu_pkg.sv ----
// Constants, codes and token layout of the token unit for increment, shifts and compares.
// Assumes one 25 MHz clock and a synchronous active-high reset in every user.
package tu_pkg;
	localparam int DATA_W   = 16;
	localparam int TOKEN_W  = 18;
	localparam int BUF_DEPTH = 2;
	localparam int ADDR_W   = 8;

	// Operation codes
	typedef enum logic [4:0] {
		plus_one_op             = 5'h0A,
		minus_one_op            = 5'h0B,
		shift_left_op           = 5'h04,
		reversed_left_shift_op  = 5'h05,
		shift_right_op          = 5'h06,
		reversed_right_shift_op = 5'h07,
		compare_normalize_op    = 5'h08,
		plain_compare_op        = 5'h09,
		compare_swap_op         = 5'h11
	} tu_op_e;

	// Condition codes, one bit each for above, below and same
	localparam logic [2:0] NO_CONDITION    = 3'h0;
	localparam logic [2:0] same_value_test = 3'h1;
	localparam logic [2:0] below_test      = 3'h2;
	localparam logic [2:0] at_most_test    = 3'h3;
	localparam logic [2:0] above_test      = 3'h4;
	localparam logic [2:0] at_least_test   = 3'h5;
	localparam logic [2:0] differ_test     = 3'h6;
	localparam int FLAG_ABOVE = 2;
	localparam int FLAG_BELOW = 1;
	localparam int FLAG_SAME  = 0;

	localparam logic [16:0] INC_LIMIT = 17'h0FFFF;
	localparam logic [16:0] DEC_LIMIT = 17'h10000;
	localparam logic [15:0] ONE_DATA  = 16'h0001;
	localparam logic [15:0] ZERO_DATA = 16'h0000;

	// Register map
	localparam logic [7:0]  CTRL_OFFS   = 8'h00;
	localparam logic [7:0]  COUNT_OFFS  = 8'h04;
	localparam logic [7:0]  FLAGS_OFFS  = 8'h08;
	localparam logic [31:0] CTRL_RESET  = 32'h00000001;
	localparam int          CTRL_EN_BIT = 0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        ctrl;
		logic        sign;
		logic [15:0] data;
	} tu_token_s;
endpackage : tu_pkg

// ---- verilog/tu_stream_if.sv ----
// Valid/ready stream carrying one result token pair between unit and buffer.
// Assumes source and sink share one clock.
`timescale 1ns/1ps
`default_nettype none
interface tu_stream_if #(parameter int W = 36);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : tu_stream_if
`default_nettype wire

// ---- verilog/tu_buf.sv ----
// Small FIFO that holds result pairs while the downstream stage stalls.
// Assumes synchronous reset; read data come straight from storage flops.
`timescale 1ns/1ps
`default_nettype none
module tu_buf #(
	parameter int W     = 36,
	parameter int DEPTH = tu_pkg::BUF_DEPTH
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// Streams
	tu_stream_if.snk  fill_s,
	tu_stream_if.src  drain_s
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0]   level_reg;
	logic          push;
	logic          pop;

	assign fill_s.ready  = (level_reg != (PW+1)'(DEPTH));
	assign drain_s.valid = (level_reg != '0);
	assign drain_s.data  = mem_reg[rd_ptr_reg];
	assign push = fill_s.valid && fill_s.ready;
	assign pop  = drain_s.valid && drain_s.ready;

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= fill_s.data;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + PW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + PW'(1);
			end
			level_reg <= level_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	chk_full_stalls: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(level_reg == (PW+1)'(DEPTH)) && !drain_s.ready |=> !fill_s.ready)
		else $error("buffer accepted while full");
	cov_buf_full: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		level_reg == (PW+1)'(DEPTH));
endmodule : tu_buf
`default_nettype wire

// ---- verilog/tu_token_unit.sv ----
// Token unit: increment/decrement, barrel and bit-reversed shifts, three compares.
// Assumes upstream holds token fields while tok_valid_i waits; one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tu_token_unit #(
	parameter int BUF_DEPTH = tu_pkg::BUF_DEPTH
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// AXI4-Lite register port
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Incoming token pair and instruction
	input  wire logic        tok_valid_i,
	output logic             tok_ready_o,
	input  wire logic [4:0]  op_i,
	input  wire logic [2:0]  condition_select_i,
	input  wire logic        a_ctrl_i,
	input  wire logic        a_sign_i,
	input  wire logic [15:0] a_data_i,
	input  wire logic        b_ctrl_i,
	input  wire logic        b_sign_i,
	input  wire logic [15:0] b_data_i,
	// Outgoing result pair
	output logic             res_valid_o,
	input  wire logic        res_ready_i,
	output logic             x_ctrl_o,
	output logic             x_sign_o,
	output logic [15:0]      x_data_o,
	output logic             y_ctrl_o,
	output logic             y_sign_o,
	output logic [15:0]      y_data_o
);
	localparam int PAIR_W = 2 * tu_pkg::TOKEN_W;

	// True when any flag named in the condition field is set
	function automatic logic cond_match(input logic [2:0] cond, input logic [2:0] flags);
		cond_match = |(cond & flags);
	endfunction : cond_match

	function automatic logic [15:0] bit_rev(input logic [15:0] v);
		for (int i = 0; i < 16; i++) begin
			bit_rev[i] = v[15-i];
		end
	endfunction : bit_rev

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == tu_pkg::CTRL_OFFS) || (a == tu_pkg::COUNT_OFFS)
			|| (a == tu_pkg::FLAGS_OFFS);
	endfunction : addr_mapped

	tu_stream_if #(.W(PAIR_W)) fill_s ();
	tu_stream_if #(.W(PAIR_W)) drain_s ();

	logic [31:0]       ctrl_reg;
	logic [31:0]       tok_count_reg;
	logic [4:0]        flags_reg;
	logic              unit_en;
	logic              tok_fire;
	logic [16:0]       a_val;
	logic [16:0]       b_val;
	logic [17:0]       diff;
	logic [2:0]        cmp_flags;
	logic [16:0]       step_val;
	logic [2:0]        step_flags;
	logic              inc_ovf;
	logic              dec_unf;
	logic              cond_true;
	logic [15:0]       shift_src;
	logic [4:0]        shift_cnt;
	logic [31:0]       shift_wide;
	tu_pkg::tu_token_s x_tok;
	tu_pkg::tu_token_s y_tok;

	assign unit_en = ctrl_reg[tu_pkg::CTRL_EN_BIT];
	assign a_val   = {a_sign_i, a_data_i};
	assign b_val   = {b_sign_i, b_data_i};

	// Subtract B from A to derive the above/below/same flags
	assign diff = {a_val[16], a_val} - {b_val[16], b_val};
	assign cmp_flags[tu_pkg::FLAG_BELOW] = diff[17];
	assign cmp_flags[tu_pkg::FLAG_SAME]  = (diff == '0);
	assign cmp_flags[tu_pkg::FLAG_ABOVE] = !diff[17] && (diff != '0);

	// Step by one on the 17-bit A value
	assign step_val = (op_i == tu_pkg::plus_one_op) ? a_val + 17'h00001 : a_val - 17'h00001;
	assign inc_ovf  = (op_i == tu_pkg::plus_one_op) && (a_val == tu_pkg::INC_LIMIT);
	assign dec_unf  = (op_i == tu_pkg::minus_one_op) && (a_val == tu_pkg::DEC_LIMIT);
	assign step_flags[tu_pkg::FLAG_BELOW] = step_val[16];
	assign step_flags[tu_pkg::FLAG_SAME]  = (step_val == '0);
	assign step_flags[tu_pkg::FLAG_ABOVE] = !step_val[16] && (step_val != '0);

	// Condition codes decode onto the flag bits
	assign cond_true = cond_match(condition_select_i,
		(op_i == tu_pkg::plus_one_op || op_i == tu_pkg::minus_one_op) ? step_flags : cmp_flags);

	// Shift source, reversed for the reversing variants
	assign shift_src = (op_i == tu_pkg::reversed_left_shift_op
		|| op_i == tu_pkg::reversed_right_shift_op) ? bit_rev(a_data_i) : a_data_i;
	assign shift_cnt = b_data_i[4:0];

	always_comb begin
		if (b_sign_i) begin
			shift_wide = {16'h0000, shift_src} << shift_cnt[3:0];
		end else begin
			shift_wide = {shift_src, 16'h0000} >> shift_cnt[3:0];
		end
	end

	// Result pair
	always_comb begin
		x_tok = '{ctrl: a_ctrl_i, sign: a_sign_i, data: a_data_i};
		y_tok = '{ctrl: b_ctrl_i, sign: b_sign_i, data: b_data_i};
		unique case (op_i)
			tu_pkg::plus_one_op, tu_pkg::minus_one_op: begin
				x_tok.sign = step_val[16];
				x_tok.data = step_val[15:0];
				y_tok.sign = dec_unf;
				y_tok.data = (inc_ovf || dec_unf) ? tu_pkg::ONE_DATA : tu_pkg::ZERO_DATA;
				if (condition_select_i != tu_pkg::NO_CONDITION) begin
					x_tok.ctrl = cond_true;
					y_tok.ctrl = cond_true;
				end
			end
			tu_pkg::shift_left_op, tu_pkg::reversed_left_shift_op,
			tu_pkg::shift_right_op, tu_pkg::reversed_right_shift_op: begin
				x_tok.sign = 1'b0;
				y_tok.sign = 1'b0;
				if (shift_cnt[4]) begin
					x_tok.data = tu_pkg::ZERO_DATA;
					y_tok.data = shift_src;
				end else if (b_sign_i) begin
					x_tok.data = shift_wide[15:0];
					y_tok.data = shift_wide[31:16];
				end else begin
					x_tok.data = shift_wide[31:16];
					y_tok.data = shift_wide[15:0];
				end
			end
			tu_pkg::compare_normalize_op: begin
				x_tok = '{ctrl: cond_true, sign: 1'b0,
					data: cond_true ? tu_pkg::ONE_DATA : tu_pkg::ZERO_DATA};
				y_tok = '{ctrl: cond_true, sign: 1'b0, data: tu_pkg::ZERO_DATA};
			end
			tu_pkg::plain_compare_op: begin
				x_tok.ctrl = 1'b1;
				y_tok.ctrl = cond_true;
			end
			tu_pkg::compare_swap_op: begin
				if (!cond_true) begin
					x_tok = '{ctrl: b_ctrl_i, sign: b_sign_i, data: b_data_i};
					y_tok = '{ctrl: a_ctrl_i, sign: a_sign_i, data: a_data_i};
				end
			end
			default: begin
				// Codes outside this unit pass both tokens unchanged
				x_tok = '{ctrl: a_ctrl_i, sign: a_sign_i, data: a_data_i};
				y_tok = '{ctrl: b_ctrl_i, sign: b_sign_i, data: b_data_i};
			end
		endcase
	end

	// Token handshake through the result buffer
	assign fill_s.valid  = tok_valid_i && unit_en;
	assign fill_s.data   = {x_tok, y_tok};
	assign tok_ready_o   = fill_s.ready && unit_en;
	assign tok_fire      = fill_s.valid && fill_s.ready;
	assign drain_s.ready = res_ready_i;
	assign res_valid_o   = drain_s.valid;
	assign {x_ctrl_o, x_sign_o, x_data_o, y_ctrl_o, y_sign_o, y_data_o} = drain_s.data;

	tu_buf #(
		.W     (PAIR_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.fill_s    (fill_s),
		.drain_s   (drain_s)
	);

	// Token count and last flags
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tok_count_reg <= '0;
			flags_reg     <= '0;
		end else if (tok_fire) begin
			tok_count_reg <= tok_count_reg + 32'h00000001;
			flags_reg     <= {inc_ovf, dec_unf, cmp_flags};
		end
	end

	// AXI4-Lite write channel
	logic        aw_held_reg;
	logic [7:0]  aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic        w_strb0_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;

	assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= '0;
			w_strb0_reg <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= tu_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held_reg  <= 1'b1;
				w_data_reg  <= s_axi_wdata_i;
				w_strb0_reg <= s_axi_wstrb_i[0];
			end
			if (aw_held_reg && w_held_reg && !bvalid_reg) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= addr_mapped(aw_addr_reg) ? tu_pkg::RESP_OKAY
					: tu_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready_i) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl_reg <= tu_pkg::CTRL_RESET;
		end else if (aw_held_reg && w_held_reg && !bvalid_reg && w_strb0_reg
			&& aw_addr_reg == tu_pkg::CTRL_OFFS) begin
			ctrl_reg <= {31'h00000000, w_data_reg[tu_pkg::CTRL_EN_BIT]};
		end
	end

	// AXI4-Lite read channel
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;

	assign s_axi_arready_o = !rvalid_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign s_axi_rresp_o   = rresp_reg;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= tu_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= addr_mapped(s_axi_araddr_i) ? tu_pkg::RESP_OKAY
				: tu_pkg::RESP_SLVERR;
			unique case (s_axi_araddr_i)
				tu_pkg::CTRL_OFFS:  rdata_reg <= ctrl_reg;
				tu_pkg::COUNT_OFFS: rdata_reg <= tok_count_reg;
				tu_pkg::FLAGS_OFFS: rdata_reg <= {27'h0000000, flags_reg};
				default:            rdata_reg <= '0;
			endcase
		end else if (rvalid_reg && s_axi_rready_i) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Checks on the computed result pair
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	chk_step_y_zero: assert property (tok_valid_i && op_i == tu_pkg::plus_one_op
		&& a_val != tu_pkg::INC_LIMIT |-> !y_tok.sign && y_tok.data == 16'h0000)
		else $error("plus one Y not zero");
	chk_step_overflow: assert property (tok_valid_i && op_i == tu_pkg::plus_one_op
		&& a_val == tu_pkg::INC_LIMIT |-> {x_tok.sign, x_tok.data} == 17'h10000
		&& !y_tok.sign && y_tok.data == 16'h0001)
		else $error("plus one overflow wrong");
	chk_step_underflow: assert property (tok_valid_i && op_i == tu_pkg::minus_one_op
		&& a_val == tu_pkg::DEC_LIMIT |-> y_tok.sign && y_tok.data == 16'h0001)
		else $error("minus one underflow wrong");
	chk_shift_right: assert property (tok_valid_i && op_i == tu_pkg::shift_right_op
		&& !b_sign_i && !b_data_i[4] |-> ((x_tok.data << b_data_i[3:0])
		| (y_tok.data >> (5'h10 - b_data_i[4:0]))) == a_data_i && (x_tok.data >> (5'h10 - b_data_i[4:0])) == 16'h0000)
		else $error("right shift lost bits");
	chk_shift_left: assert property (tok_valid_i && op_i == tu_pkg::shift_left_op
		&& b_sign_i && b_data_i[4:0] == 5'h01 |-> x_tok.data == {a_data_i[14:0], 1'b0}
		&& y_tok.data == {15'h0000, a_data_i[15]})
		else $error("left shift by one wrong");
	chk_shift_large: assert property (tok_valid_i && op_i == tu_pkg::shift_right_op
		&& b_data_i[4] |-> x_tok.data == 16'h0000 && y_tok.data == a_data_i)
		else $error("large count wrong");
	chk_reverse_order: assert property (tok_valid_i
		&& op_i == tu_pkg::reversed_right_shift_op && b_data_i[4:0] == 5'h00
		|-> x_tok.data[0] == a_data_i[15] && x_tok.data[15] == a_data_i[0])
		else $error("bit reversal wrong");
	chk_below_decode: assert property (tok_valid_i && op_i == tu_pkg::plain_compare_op
		&& condition_select_i == tu_pkg::below_test |-> y_tok.ctrl == ($signed(a_val) < $signed(b_val)))
		else $error("below test wrong");
	chk_normalize_out: assert property (tok_valid_i
		&& op_i == tu_pkg::compare_normalize_op |-> x_tok.data == {15'h0000, x_tok.ctrl}
		&& x_tok.ctrl == y_tok.ctrl && !x_tok.sign && y_tok.data == 16'h0000)
		else $error("normalize output wrong");
	chk_swap_false: assert property (tok_valid_i && op_i == tu_pkg::compare_swap_op
		&& condition_select_i == tu_pkg::same_value_test && a_val != b_val
		|-> x_tok.data == b_data_i && y_tok.data == a_data_i && x_tok.ctrl == b_ctrl_i)
		else $error("swap on false wrong");
	chk_shift_ctrl: assert property (tok_valid_i && op_i == tu_pkg::shift_left_op
		|-> x_tok.ctrl == a_ctrl_i && y_tok.ctrl == b_ctrl_i && !x_tok.sign && !y_tok.sign)
		else $error("shift control bits wrong");
	chk_token_drains: assert property (tok_fire && !res_valid_o ##1 res_ready_i
		|-> res_valid_o && x_data_o == $past(x_tok.data))
		else $error("buffered pair lost");

	cov_inc_overflow: cover property (tok_fire && inc_ovf);
	cov_swap_false: cover property (tok_fire && op_i == tu_pkg::compare_swap_op && !cond_true);
	cov_stall_then_drain: cover property (res_valid_o && !res_ready_i ##1 res_ready_i);
endmodule : tu_token_unit
`default_nettype wire

// ---- verif/tu_stage_model.sv ----
// Issuing stage ahead of the token unit and sink stage behind it.
// Assumes its tasks are called just after a rising edge of ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module tu_stage_model (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	// Issue side
	output logic                   tok_valid_o,
	input  wire logic              tok_ready_i,
	output logic [4:0]             op_o,
	output logic [2:0]             cond_o,
	output var tu_pkg::tu_token_s  a_o,
	output var tu_pkg::tu_token_s  b_o,
	// Result side
	input  wire logic              res_valid_i,
	output logic                   res_ready_o,
	input  wire logic [35:0]       pair_i
);
	logic        hold  = 1'b0;
	logic        slow  = 1'b0;
	logic        phase = 1'b0;
	int          n_sent = 0;
	logic [35:0] got_q[$];

	initial begin
		tok_valid_o = 1'b0;
		op_o = 5'h00;
		cond_o = 3'h0;
		a_o = 18'h00000;
		b_o = 18'h00000;
		res_ready_o = 1'b0;
	end

	// Sink stalls on hold, or takes every other cycle when slow
	always @(posedge ref_clk_i) begin
		phase <= !phase;
		res_ready_o <= !rst_i && !hold && (!slow || phase);
		if (!rst_i && res_valid_i && res_ready_o)
			got_q.push_back(pair_i);
		if (!rst_i && tok_valid_o && tok_ready_i)
			n_sent <= n_sent + 1;
	end

	// Fields stay put until the unit takes them
	task automatic send(input logic [4:0] op, input logic [2:0] cond,
		input tu_pkg::tu_token_s a, input tu_pkg::tu_token_s b);
		tok_valid_o <= 1'b1;
		op_o <= op;
		cond_o <= cond; // compares only ever get codes 3'h1 to 3'h6
		a_o <= a;
		b_o <= b;
		@(posedge ref_clk_i);
		while (!tok_ready_i) @(posedge ref_clk_i);
	endtask : send

	task automatic idle();
		tok_valid_o <= 1'b0;
	endtask : idle

	task automatic take(output logic [35:0] r);
		while (got_q.size() == 0) @(posedge ref_clk_i);
		r = got_q.pop_front();
	endtask : take
endmodule : tu_stage_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the token unit: ops, buffer stall, registers.
// Assumes tu_stage_model drives the token ports; bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int PERIOD = 40;
	logic        ref_clk_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic [7:0]  aw_addr   = 8'h00;
	logic        aw_valid  = 1'b0;
	logic [31:0] w_data    = 32'h00000000;
	logic        w_valid   = 1'b0;
	logic        b_ready   = 1'b0;
	logic [7:0]  ar_addr   = 8'h00;
	logic        ar_valid  = 1'b0;
	logic        r_ready   = 1'b0;
	logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic [1:0]  b_resp, r_resp;
	logic [31:0] r_data;
	logic        tok_valid, tok_ready, res_valid, res_ready;
	logic [4:0]  op;
	logic [2:0]  cond;
	tu_pkg::tu_token_s a, b;
	logic        x_c, x_s, y_c, y_s;
	logic [15:0] x_d, y_d;
	int          n_mismatch = 0;
	int          samples_checked = 0;

	always #(PERIOD / 2) ref_clk_i = ~ref_clk_i;

	tu_token_unit dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
		.s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_valid),
		.s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
		.s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
		.s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
		.s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready),
		.tok_valid_i(tok_valid), .tok_ready_o(tok_ready), .op_i(op),
		.condition_select_i(cond), .a_ctrl_i(a.ctrl), .a_sign_i(a.sign), .a_data_i(a.data),
		.b_ctrl_i(b.ctrl), .b_sign_i(b.sign), .b_data_i(b.data),
		.res_valid_o(res_valid), .res_ready_i(res_ready), .x_ctrl_o(x_c), .x_sign_o(x_s),
		.x_data_o(x_d), .y_ctrl_o(y_c), .y_sign_o(y_s), .y_data_o(y_d));

	tu_stage_model p (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .tok_valid_o(tok_valid),
		.tok_ready_i(tok_ready), .op_o(op), .cond_o(cond), .a_o(a), .b_o(b),
		.res_valid_i(res_valid), .res_ready_o(res_ready),
		.pair_i({x_c, x_s, x_d, y_c, y_s, y_d}));

	task automatic chk_pair(input logic [35:0] exp, input logic [35:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask : chk_pair

	task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask : chk_word

	task automatic reg_write(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
		aw_addr <= ad;
		aw_valid <= 1'b1;
		w_data <= d;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (aw_valid && aw_ready) aw_valid <= 1'b0;
			if (w_valid && w_ready) w_valid <= 1'b0;
		end while (!b_valid);
		rs = b_resp;
		b_ready <= 1'b0;
		@(posedge ref_clk_i);
	endtask : reg_write

	task automatic reg_read(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
		ar_addr <= ad;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (ar_valid && ar_ready) ar_valid <= 1'b0;
		end while (!r_valid);
		d = r_data;
		rs = r_resp;
		r_ready <= 1'b0;
		@(posedge ref_clk_i);
	endtask : reg_read

	function automatic logic [15:0] rev16(input logic [15:0] v);
		for (int k = 0; k < 16; k++) rev16[k] = v[15 - k];
	endfunction : rev16

	task automatic do_op(input logic [4:0] o, input logic [2:0] c,
		input logic [17:0] ta, input logic [17:0] tb, output logic [35:0] r);
		p.send(o, c, ta, tb);
		p.idle();
		p.take(r);
	endtask : do_op

	task automatic t_incdec();
		logic [35:0] r;
		do_op(tu_pkg::plus_one_op, 3'h0, {1'b1, 17'h00005}, {1'b0, 17'h00009}, r);
		chk_pair({1'b1, 17'h00006, 1'b0, 17'h00000}, r);
		do_op(tu_pkg::plus_one_op, 3'h0, {1'b0, 17'h0FFFF}, {1'b1, 17'h00000}, r);
		chk_pair({1'b0, 17'h10000, 1'b1, 17'h00001}, r);
		do_op(tu_pkg::minus_one_op, 3'h0, {1'b1, 17'h10000}, {1'b1, 17'h0}, r);
		chk_pair({1'b1, 17'h0FFFF, 1'b1, 17'h10001}, r);
		do_op(tu_pkg::minus_one_op, 3'h0, {1'b0, 17'h00000}, {1'b1, 17'h0}, r);
		chk_pair({1'b0, 17'h1FFFF, 1'b1, 17'h00000}, r);
		do_op(tu_pkg::plus_one_op, tu_pkg::above_test, {1'b0, 17'h00005}, {1'b0, 17'h00009}, r);
		chk_pair({1'b1, 17'h00006, 1'b1, 17'h00000}, r);
		do_op(tu_pkg::minus_one_op, tu_pkg::below_test, {1'b1, 17'h00005}, {1'b1, 17'h0}, r);
		chk_pair({1'b0, 17'h00004, 1'b0, 17'h00000}, r);
		$display("incdec test done");
	endtask : t_incdec

	task automatic t_shift();
		logic [4:0]  o;
		logic [4:0]  n;
		logic [15:0] ad;
		logic [31:0] w;
		logic [35:0] r;
		logic [4:0]  cnt[6] = '{5'h00, 5'h01, 5'h03, 5'h0F, 5'h10, 5'h1F};
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 6; j++) begin
				for (int s = 0; s < 2; s++) begin
					o = tu_pkg::shift_left_op + 5'(i);
					n = cnt[j];
					ad = o[0] ? rev16(16'hB38D) : 16'hB38D;
					w = s ? {16'h0, ad} << n : {ad, 16'h0} >> n;
					if (s) w = {w[15:0], w[31:16]};
					if (n[4]) w = {16'h0, ad};
					do_op(o, 3'h0, {2'b11, 16'hB38D}, {1'b0, s[0], 11'h2A5, n}, r);
					chk_pair({2'b10, w[31:16], 2'b00, w[15:0]}, r);
				end
			end
		end
		$display("shift test done");
	endtask : t_shift

	task automatic t_compare();
		logic [16:0] av[3] = '{17'h01234, 17'h1FFFE, 17'h00100};
		logic [16:0] bv[3] = '{17'h01234, 17'h00003, 17'h18000};
		logic [4:0]  o;
		logic [35:0] r;
		logic [35:0] e;
		logic        t;
		logic        lt;
		logic        eq;
		p.slow = 1'b1;
		for (int c = 1; c < 7; c++) begin
			for (int k = 0; k < 3; k++) begin
				lt = $signed(av[k]) < $signed(bv[k]);
				eq = av[k] == bv[k];
				t = (c[2] && !lt && !eq) || (c[1] && lt) || (c[0] && eq);
				for (int m = 0; m < 3; m++) begin
					o = (m == 0) ? tu_pkg::compare_normalize_op :
						(m == 1) ? tu_pkg::plain_compare_op : tu_pkg::compare_swap_op;
					do_op(o, c[2:0], {1'b1, av[k]}, {1'b0, bv[k]}, r);
					e = t ? {1'b1, av[k], 1'b0, bv[k]} : {1'b0, bv[k], 1'b1, av[k]};
					if (m == 0) chk_pair(t ? {18'h20001, 18'h20000} : 36'h0, r);
					if (m == 1) chk_pair({1'b1, av[k], t, bv[k]}, r);
					if (m == 2) chk_pair(e, r);
				end
			end
		end
		p.slow = 1'b0;
		$display("compare test done");
	endtask : t_compare

	task automatic t_stall();
		logic [35:0] r;
		p.hold = 1'b1;
		p.send(tu_pkg::plus_one_op, 3'h0, 18'h00010, 18'h00000);
		p.send(tu_pkg::minus_one_op, 3'h0, 18'h00010, 18'h00000);
		p.idle();
		repeat (3) @(posedge ref_clk_i);
		chk_word(32'h1, {31'h0, res_valid});
		chk_word(32'h0, {31'h0, tok_ready});
		p.hold = 1'b0;
		p.take(r);
		chk_pair({18'h00011, 18'h00000}, r);
		p.take(r);
		chk_pair({18'h0000F, 18'h00000}, r);
		$display("stall test done");
	endtask : t_stall

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  rs;
		reg_read(tu_pkg::CTRL_OFFS, d, rs);
		chk_word(tu_pkg::CTRL_RESET, d);
		reg_read(tu_pkg::COUNT_OFFS, d, rs);
		chk_word(32'(p.n_sent), d);
		reg_read(tu_pkg::FLAGS_OFFS, d, rs);
		chk_word(32'h00000004, d);
		chk_word({30'h0, tu_pkg::RESP_OKAY}, {30'h0, rs});
		reg_read(8'h0C, d, rs);
		chk_word(32'h0, d);
		chk_word({30'h0, tu_pkg::RESP_SLVERR}, {30'h0, rs});
		reg_write(tu_pkg::CTRL_OFFS, 32'h0, rs);
		chk_word({30'h0, tu_pkg::RESP_OKAY}, {30'h0, rs});
		chk_word(32'h0, {31'h0, tok_ready});
		reg_write(tu_pkg::CTRL_OFFS, 32'h1, rs);
		chk_word(32'h1, {31'h0, tok_ready});
		$display("register test done");
	endtask : t_regs

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		t_incdec();
		t_shift();
		t_compare();
		t_stall();
		t_regs();
		report_and_stop();
	end

	initial begin
		#(20000 * PERIOD);
		n_mismatch++;
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
